// ---- logic/logic_tile.v ----
// logic_tile.v: four-slice logic tile with LUTs, ripple, RAM and ROM
// assumes fabric inputs synchronous to clk; configured over APB
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "tile_map.vh"

module logic_tile (
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire [15:0] lut_in_low,
    input  wire [15:0] lut_in_high,
    input  wire [7:0]  multi_purpose_in,
    input  wire [3:0]  ce,
    input  wire [3:0]  local_set_reset,
    input  wire [3:0]  slice_clk,
    input  wire        carry_chain_in,
    output wire [3:0]  lut_out_low,
    output wire [3:0]  lut_out_high,
    output wire [3:0]  reg_out_low,
    output wire [3:0]  reg_out_high,
    output wire [3:0]  five_input_mux_out,
    output wire [3:0]  wide_mux_out,
    output wire        carry_chain_out
);

// -----------------------------------------------------------------
// functions
// -----------------------------------------------------------------
function lut4;
    input [15:0] tt;
    input [3:0]  ix;
    begin
        lut4 = tt[ix];
    end
endfunction

function [3:0] nib;
    input [15:0] v;
    input [1:0]  s;
    begin
        nib = v[{s, 2'b00} +: 4];
    end
endfunction

function reg_ok;
    input [7:0] a;
    begin
        reg_ok = (a[1:0] == 2'b00) && (a <= `STAT_OFS);
    end
endfunction

// mode field of one slice configuration word
function [1:0] mode_of;
    input [`CF_W-1:0] c;
    begin
        mode_of = c[`CF_MODE_HI:`CF_MODE_LO];
    end
endfunction

// -----------------------------------------------------------------
// state
// -----------------------------------------------------------------
// truth tables: index 2s is the low lut, 2s+1 the high lut of slice s
reg  [15:0]      tt_ff [0:7];
reg  [`CF_W-1:0] cfg_ff [0:3];
reg              user_ff;
reg  [7:0]       q_ff;
reg  [3:0]       clk_prev_ff;
reg  [31:0]      prdata_ff;
reg              pready_ff;
reg              pslverr_ff;

reg  [3:0]       lut_lo_c;
reg  [3:0]       lut_hi_c;
reg  [3:0]       fx_c;
reg  [3:0]       wm_c;
reg  [7:0]       d_c;
reg  [4:0]       cy;
reg  [3:0]       sclk;
reg  [3:0]       cap;
reg  [3:0]       sr_act;
reg  [3:0]       lo;
reg  [3:0]       hi;
reg  [1:0]       md;
reg  [2:0]       op;
reg  [1:0]       a;
reg  [1:0]       b;
reg  [1:0]       x;
reg  [1:0]       y;
reg  [1:0]       qv;
reg  [1:0]       g;
reg  [1:0]       p;
reg  [1:0]       sum;
reg              ci;
reg              aci;
reg              c1;
reg              c2;
reg              dn;
reg  [31:0]      rd_c;
integer          s;
integer          i;
integer          j;

wire       apb_wr = psel & penable & pwrite;
wire       setup  = psel & ~penable;
// slice 2 lut inputs carry the RAM write address and data
wire [3:0] wa     = lut_in_low[11:8];
wire [3:0] wbits  = lut_in_high[11:8];
// slices 0 and 1 store, slice 2 addresses: three slices per RAM
wire       ram_en = user_ff & local_set_reset[2] &
                    (mode_of(cfg_ff[2]) == `MODE_RAM);

// -----------------------------------------------------------------
// slice datapath and carry chain
// -----------------------------------------------------------------
always @* begin
    // defaults keep every variable assigned on every path
    cy      = 5'h00;
    cy[0]   = carry_chain_in;
    lut_lo_c = 4'h0;
    lut_hi_c = 4'h0;
    fx_c    = 4'h0;
    d_c     = 8'h00;
    sclk    = 4'h0;
    cap     = 4'h0;
    sr_act  = 4'h0;
    lo = 4'h0;
    hi = 4'h0;
    md = 2'h0;
    op = 3'h0;
    a  = 2'h0;
    b  = 2'h0;
    x  = 2'h0;
    y  = 2'h0;
    qv = 2'h0;
    g  = 2'h0;
    p  = 2'h0;
    sum = 2'h0;
    ci  = 1'b0;
    aci = 1'b0;
    c1  = 1'b0;
    c2  = 1'b0;
    dn  = 1'b0;
    for (s = 0; s < 4; s = s + 1) begin
        lo = nib(lut_in_low, s[1:0]);
        hi = nib(lut_in_high, s[1:0]);
        md = mode_of(cfg_ff[s]);
        op = cfg_ff[s][`CF_OP_HI:`CF_OP_LO];
        lut_lo_c[s] = lut4(tt_ff[2*s], lo);
        lut_hi_c[s] = lut4(tt_ff[2*s+1], hi);
        fx_c[s] = multi_purpose_in[2*s] ? lut_hi_c[s] : lut_lo_c[s];
        d_c[2*s]   = lut_lo_c[s];
        d_c[2*s+1] = lut_hi_c[s];
        cy[s+1]    = cy[s];
        // fast carry takes the chain, plain ripple a local carry
        ci = cfg_ff[s][`CF_FAST] ? cy[s] : multi_purpose_in[2*s+1];
        // ripple: operand A from input A of both luts, B from input B
        if (md == `MODE_RIPPLE) begin
            a  = {hi[0], lo[0]};
            b  = {hi[1], lo[1]};
            qv = {q_ff[2*s+1], q_ff[2*s]};
            x  = a;
            y  = b;
            dn = 1'b0;
            case (op)
                `OP_SUB: y = ~b;
                `OP_ADDSUB: y = lo[2] ? ~b : b;
                `OP_UP: begin
                    x = qv;
                    y = 2'b00;
                end
                `OP_DOWN: begin
                    x  = qv;
                    y  = 2'b11;
                    dn = 1'b1;
                end
                `OP_UPDN: begin
                    x  = qv;
                    y  = lo[2] ? 2'b11 : 2'b00;
                    dn = lo[2];
                end
                `OP_CMP: y = ~b;
                `OP_MULT: y = b & {2{lo[2]}};
                default: y = b;
            endcase
            // counters step when carry in is high
            aci = dn ? ~ci : ci;
            g   = x & y;
            p   = x ^ y;
            c1  = g[0] | (p[0] & aci);
            c2  = g[1] | (p[1] & c1);
            sum = p ^ {c1, aci};
            cy[s+1] = dn ? ~c2 : c2;
            lut_lo_c[s] = sum[0];
            lut_hi_c[s] = sum[1];
            d_c[2*s]   = sum[0];
            d_c[2*s+1] = sum[1];
            if (op == `OP_UPDN && lo[3]) begin
                d_c[2*s]   = b[0];
                d_c[2*s+1] = b[1];
            end
            if (op == `OP_CMP) begin
                lut_lo_c[s] = c2;
                lut_hi_c[s] = (a != b);
                fx_c[s] = (a <= b);
            end
        end
        // clock select, polarity, edge or latch
        sclk[s] = slice_clk[cfg_ff[s][`CF_CSEL_HI:`CF_CSEL_LO]];
        if (cfg_ff[s][`CF_LATCH])
            cap[s] = ~(sclk[s] ^ cfg_ff[s][`CF_POL]);
        else if (cfg_ff[s][`CF_POL])
            cap[s] = sclk[s] & ~clk_prev_ff[s];
        else
            cap[s] = ~sclk[s] & clk_prev_ff[s];
        // slice 2 set/reset is the write enable in RAM mode
        sr_act[s] = local_set_reset[s] &
                    ~(s == 2 && md == `MODE_RAM);
    end
    // lut6 per slice pair, lut7 joins both pairs, copy exported for lut8
    wm_c[1] = multi_purpose_in[3] ? fx_c[1] : fx_c[0];
    wm_c[3] = multi_purpose_in[7] ? fx_c[3] : fx_c[2];
    wm_c[2] = multi_purpose_in[5] ? wm_c[3] : wm_c[1];
    wm_c[0] = wm_c[2];
end

assign lut_out_low        = lut_lo_c;
assign lut_out_high       = lut_hi_c;
assign five_input_mux_out = fx_c;
assign wide_mux_out       = wm_c;
assign carry_chain_out    = cy[4];

// -----------------------------------------------------------------
// slice registers
// -----------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        q_ff        <= 8'h00;
        clk_prev_ff <= 4'h0;
    end else begin
        clk_prev_ff <= sclk;
        for (i = 0; i < 4; i = i + 1) begin
            // outside user mode every register is forced to its init
            if (!user_ff) begin
                q_ff[2*i]   <= cfg_ff[i][`CF_INIT_LO];
                q_ff[2*i+1] <= cfg_ff[i][`CF_INIT_HI];
            // async set/reset acts every clk, sync only on capture
            end else if (sr_act[i] && !cfg_ff[i][`CF_SYNC]) begin
                q_ff[2*i]   <= cfg_ff[i][`CF_INIT_LO];
                q_ff[2*i+1] <= cfg_ff[i][`CF_INIT_HI];
            end else if (cap[i]) begin
                if (sr_act[i]) begin
                    q_ff[2*i]   <= cfg_ff[i][`CF_INIT_LO];
                    q_ff[2*i+1] <= cfg_ff[i][`CF_INIT_HI];
                end else if (ce[i]) begin
                    q_ff[2*i]   <= d_c[2*i];
                    q_ff[2*i+1] <= d_c[2*i+1];
                end
            end
        end
    end
end

assign reg_out_low  = {q_ff[6], q_ff[4], q_ff[2], q_ff[0]};
assign reg_out_high = {q_ff[7], q_ff[5], q_ff[3], q_ff[1]};

// -----------------------------------------------------------------
// truth tables, distributed RAM and configuration registers
// -----------------------------------------------------------------
always @(posedge clk or posedge rst) begin
    if (rst) begin
        for (j = 0; j < 8; j = j + 1)
            tt_ff[j] <= 16'h0000;
        for (j = 0; j < 4; j = j + 1)
            cfg_ff[j] <= `CFG_RST;
        user_ff <= 1'b0;
    end else begin
        if (apb_wr && reg_ok(paddr)) begin
            if (paddr < `CFG_BASE) begin
                if (!user_ff)
                    tt_ff[paddr[4:2]] <= pwdata[15:0];
            end else if (paddr < `CTRL_OFS) begin
                cfg_ff[paddr[3:2]] <= pwdata[`CF_W-1:0];
            end else if (paddr == `CTRL_OFS) begin
                user_ff <= pwdata[`CTRL_USER];
            end
        end
        // only slices 0 and 1 hold RAM bits, never slice 3
        if (ram_en && mode_of(cfg_ff[0]) == `MODE_RAM) begin
            tt_ff[0][wa] <= wbits[0];
            tt_ff[1][wa] <= wbits[1];
        end
        if (ram_en && mode_of(cfg_ff[1]) == `MODE_RAM) begin
            tt_ff[2][wa] <= wbits[2];
            tt_ff[3][wa] <= wbits[3];
        end
    end
end

// -----------------------------------------------------------------
// APB slave, zero wait states
// -----------------------------------------------------------------
always @* begin
    rd_c = 32'h0000_0000;
    if (paddr < `CFG_BASE)
        rd_c = {16'h0000, tt_ff[paddr[4:2]]};
    else if (paddr < `CTRL_OFS)
        rd_c = {19'h00000, cfg_ff[paddr[3:2]]};
    else if (paddr == `CTRL_OFS)
        rd_c = {31'h00000000, user_ff};
    else if (paddr == `STAT_OFS)
        rd_c = {22'h000000, user_ff, cy[4], q_ff};
end

always @(posedge clk or posedge rst) begin
    if (rst) begin
        prdata_ff  <= 32'h0000_0000;
        pready_ff  <= 1'b0;
        pslverr_ff <= 1'b0;
    end else begin
        // never stalls: every access phase completes in one cycle
        pready_ff <= 1'b1;
        // answer latched in setup so it stands through the access phase
        if (setup) begin
            prdata_ff  <= reg_ok(paddr) ? rd_c : 32'h0000_0000;
            pslverr_ff <= ~reg_ok(paddr);
        end
    end
end

assign prdata  = prdata_ff;
assign pready  = pready_ff;
assign pslverr = pslverr_ff;

endmodule // logic_tile
`default_nettype wire

// ---- logic/tile_map.vh ----
// tile_map.vh: offsets, field positions and codes of logic_tile
// assumes a 32-bit APB slave decoding byte addresses paddr[7:0]
`ifndef TILE_MAP_VH
`define TILE_MAP_VH

// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define TT_BASE    8'h00
`define CFG_BASE   8'h20
`define CTRL_OFS   8'h30
`define STAT_OFS   8'h34

// -----------------------------------------------------------------
// slice configuration fields
// -----------------------------------------------------------------
`define CF_W       13
`define CF_MODE_LO 0
`define CF_MODE_HI 1
`define CF_OP_LO   2
`define CF_OP_HI   4
`define CF_FAST    5
`define CF_POL     6
`define CF_LATCH   7
`define CF_SYNC    8
`define CF_INIT_LO 9
`define CF_INIT_HI 10
`define CF_CSEL_LO 11
`define CF_CSEL_HI 12
`define CFG_RST    13'h0040
`define CTRL_USER  0
`define STAT_CO    8
`define STAT_USER  9

// -----------------------------------------------------------------
// modes and ripple operations
// -----------------------------------------------------------------
`define MODE_LOGIC  2'h0
`define MODE_RIPPLE 2'h1
`define MODE_RAM    2'h2
`define MODE_ROM    2'h3
`define OP_ADD      3'h0
`define OP_SUB      3'h1
`define OP_ADDSUB   3'h2
`define OP_UP       3'h3
`define OP_DOWN     3'h4
`define OP_UPDN     3'h5
`define OP_CMP      3'h6
`define OP_MULT     3'h7

`endif

// ---- dv/logic_tile_checker.sv ----
// assertions on the APB and register ports of logic_tile
// assumes a bind into logic_tile; one clock domain
`timescale 1ns/10ps
`default_nettype none
module logic_tile_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [3:0]  ce,
    input wire logic [3:0]  local_set_reset,
    input wire logic [3:0]  reg_out_low,
    input wire logic [3:0]  reg_out_high
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire setup = psel & ~penable;
    wire rdsu  = setup & ~pwrite;

    property p_ready; !$past(rst) |-> pready; endproperty
    property p_misal; setup && paddr[1:0] != 2'h0 |=> pslverr && prdata == 0;
    endproperty
    property p_unmap; setup && paddr > 8'h34 |=> pslverr && prdata == 0;
    endproperty
    property p_mapped;
        setup && paddr <= 8'h34 && paddr[1:0] == 2'h0 |=> !pslverr;
    endproperty
    property p_hold;
        psel && penable |=> $stable(prdata) && $stable(pslverr);
    endproperty
    property p_tt_wid; rdsu && paddr < 8'h20 |=> prdata[31:16] == 0;
    endproperty
    property p_st_wid; rdsu && paddr == 8'h34 |=> prdata[31:10] == 0;
    endproperty
    property p_reg_hold;
        !psel && !$past(psel) && (ce | local_set_reset) == 4'h0
            |=> $stable({reg_out_high, reg_out_low});
    endproperty

    a_ready: assert property (p_ready) else $error("pready low");
    a_misal: assert property (p_misal) else $error("misaligned ok");
    a_unmap: assert property (p_unmap) else $error("unmapped ok");
    a_mapped: assert property (p_mapped) else $error("mapped error");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_tt_wid: assert property (p_tt_wid) else $error("table wide");
    a_st_wid: assert property (p_st_wid) else $error("status wide");
    a_reg_hold: assert property (p_reg_hold) else $error("reg moved");
    c_wr: cover property (setup && pwrite);
    c_err: cover property (pslverr);
    c_reg: cover property ($changed(reg_out_low));
endmodule // logic_tile_checker
`default_nettype wire

// ---- dv/fabric_model.sv ----
// routing fabric and neighbour tiles feeding one logic tile
// assumes bench requests; one clk of routing delay, quiet in reset
`timescale 1ns/10ps
`default_nettype none
module fabric_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [52:0] req,
    output logic      [15:0] lut_in_low,
    output logic      [15:0] lut_in_high,
    output logic      [7:0]  multi_purpose_in,
    output logic      [3:0]  ce,
    output logic      [3:0]  local_set_reset,
    output logic      [3:0]  slice_clk,
    output logic             carry_chain_in
);
    logic [52:0] q_ff;

    // slice clocks only move when the bench asks
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            q_ff <= 53'h0;
        else
            q_ff <= req;
    end
    assign {carry_chain_in, slice_clk, local_set_reset, ce,
            multi_purpose_in, lut_in_high, lut_in_low} = q_ff;
endmodule // fabric_model
`default_nettype wire

// ---- dv/logic_tile_tb_top.sv ----
// self-checking bench for logic_tile over APB and fabric pins
// assumes tile_map.vh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "tile_map.vh"
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module logic_tile_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err;
    logic [52:0] fab = 53'h0;
    logic [15:0] li_lo, li_hi;
    logic [7:0]  mpi;
    logic [3:0]  cen, sr_in, sclk, lo, hi, rlo, rhi, fmx, wmx;
    logic        cin, cout;
    int          error_cnt = 0;
    int          checked = 0;
    int          cyc = 0;
    localparam logic [15:0] truth0 = 16'hb4e1;

    always #2.5 clk = ~clk;

    fabric_model u_fab (.clk(clk), .rst(rst), .req(fab),
        .lut_in_low(li_lo), .lut_in_high(li_hi), .multi_purpose_in(mpi),
        .ce(cen), .local_set_reset(sr_in), .slice_clk(sclk),
        .carry_chain_in(cin));
    logic_tile dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lut_in_low(li_lo),
        .lut_in_high(li_hi), .multi_purpose_in(mpi), .ce(cen),
        .local_set_reset(sr_in), .slice_clk(sclk), .carry_chain_in(cin),
        .lut_out_low(lo), .lut_out_high(hi), .reg_out_low(rlo),
        .reg_out_high(rhi), .five_input_mux_out(fmx),
        .wide_mux_out(wmx), .carry_chain_out(cout));

    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        apb(0, `CFG_BASE, 0);
        `CHK("cfg0", `CFG_RST, rd);
        apb(0, 8'h38, 0);
        `CHK("unmapped", 1, err);
        apb(1, 8'h06, 32'h1);
        `CHK("misaligned", 1, err);
        apb(1, `CFG_BASE + 8'h08, 32'h0240);
        apb(0, `STAT_OFS, 0);
        `CHK("init s2", 1, rd[4]);
        `CHK("init s2 pin", 1, rlo[2]);
        `CHK("init s2 hi", 0, rhi[2]);
        apb(1, `TT_BASE, {16'h0, truth0});
        apb(1, `CTRL_OFS, 32'h1);
        apb(1, `TT_BASE, 32'h0);
        apb(0, `TT_BASE, 0);
        `CHK("table kept", truth0, rd);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            fab[3:0] <= i[3:0];
            step(3);
            `CHK("lut s0", truth0[i], lo[0]);
            `CHK("lut5 s0", truth0[i], fmx[0]);
            `CHK("lut7", truth0[i], wmx[0]);
        end
        @(posedge clk);
        fab[3:0] <= 4'h0;
        fab[40] <= 1'b1;
        fab[48] <= 1'b1;
        step(4);
        `CHK("capture", 1, rlo[0]);
        fab[3:0] <= 4'h1;
        fab[40] <= 1'b0;
        fab[48] <= 1'b0;
        step(3);
        fab[48] <= 1'b1;
        step(4);
        `CHK("ce hold", 1, rlo[0]);
        fab[44] <= 1'b1;
        step(3);
        `CHK("async init", 0, rlo[0]);
        apb(1, `CFG_BASE, 32'h0061);
        for (int v = 0; v < 32; v++) begin
            fab <= {v[4], 34'h0, v[3], v[1], 14'h0, v[2], v[0]};
            step(3);
            `CHK("add", ((v & 3) + ((v >> 2) & 3) + v[4]) & 3,
                 {hi[0], lo[0]});
            `CHK("carry out", ((v & 3) + ((v >> 2) & 3) + v[4]) >> 2,
                 cout);
        end
        apb(1, `CFG_BASE, 32'h0079);
        for (int v = 0; v < 16; v++) begin
            fab <= {1'b1, 34'h0, v[3], v[1], 14'h0, v[2], v[0]};
            step(3);
            `CHK("ge", (v & 3) >= (v >> 2), lo[0]);
            `CHK("ne", (v & 3) != (v >> 2), hi[0]);
            `CHK("le", (v & 3) <= (v >> 2), fmx[0]);
            `CHK("ge chain", (v & 3) >= (v >> 2), cout);
        end
        for (int s = 0; s < 4; s++)
            apb(1, `CFG_BASE + 8'(4 * s), 32'h0042);
        @(posedge clk);
        fab <= {5'h0, 4'h4, 12'h0, 16'h5a55, 16'h5555};
        step(3);
        fab[46] <= 1'b0;
        step(3);
        `CHK("ram word", 4'ha, {hi[1], lo[1], hi[0], lo[0]});
        `CHK("slice3", 0, {hi[3], lo[3]});
        final_report();
    end
endmodule // logic_tile_tb_top

bind logic_tile logic_tile_checker u_chk (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ce(ce),
    .local_set_reset(local_set_reset), .reg_out_low(reg_out_low),
    .reg_out_high(reg_out_high));
`default_nettype wire
